// file: usb_status_params.svh
// Constants for the USB device status and reset block.
`ifndef USB_STATUS_PARAMS_SVH
`define USB_STATUS_PARAMS_SVH
`define ADDR_INT_STATUS 6'h00
`define ADDR_INT_ENABLE 6'h04
`define ADDR_ERR_ENABLE 6'h08
`define ADDR_TRANS_STATUS 6'h0c
`define ADDR_FRAME_LOW 6'h10
`define ADDR_FRAME_HIGH 6'h14
`define ADDR_CONTROL_ZERO 6'h18
`define ADDR_DEV_ADDRESS 6'h1c
`define ADDR_DEV_STATE 6'h20
`define ADDR_LP_STATUS 6'h24
`define BIT_BUS_RESET 0
`define BIT_TOKEN_DONE 3
`define BIT_FRAME_START 2
`define BIT_RESUME 5
`define BIT_CHK_ERR 1
`define BIT_PID_ERR 0
`define BIT_CHK_FLAG 6
`define BIT_PID_FLAG 7
`define BIT_MOD_RESET 7
`define BIT_DRIVE_RESUME 2
`define BIT_REG_ENABLE 6
`define BIT_CLOCK_ENABLE 4
`define BIT_LP_RESUME_EN 0
`define BIT_LP_SUSPEND 1
`define CTL0_RESET_VAL 8'h10
`define FIFO_DEPTH 4
`define FIFO_CNT_W 3
`define CLK_MHZ 20
`define BUS_RESET_NS 2500
`define BUS_RESET_CYC ((`BUS_RESET_NS * `CLK_MHZ + 999) / 1000 + 1)
`define SE0_CNT_W 6
`endif

// file: usb_status_pkg.sv
// Types shared by the USB device status and reset block.
`default_nettype none
package usb_status_pkg;
	typedef enum logic [1:0] {dev_unconfigured, dev_addressed, dev_configured} dev_state_t;
	typedef enum logic [1:0] {line_j, line_k, line_se0, line_se1} line_state_t;
endpackage : usb_status_pkg
`default_nettype wire

// file: usb_device_status.sv
// USB device status FIFO, frame number, bus reset, resume and control registers over AHB-Lite.
// How it works
// - Transaction status reads meaningful only while token-complete flag is set.
// - Each completed descriptor use pushes a status byte unless the queue is full.
// - Status queue is a four entry byte FIFO.
// - Clearing token-complete flag advances the FIFO to the next entry.
// - If another entry waits, token-complete flag sets again at once.
// - Status bits 7..4 hold the binary endpoint number.
// - Start-of-frame token sets the frame start flag.
// - Frame number readable through low and high registers.
// - Bus reset recognised when SE0 lasts longer than 2.5 us.
// - Bus reset returns state to unconfigured and address to zero.
// - Bus reset sets the bus reset flag; firmware must service it.
// - Module reset masks interrupts, enables clock, disables regulator.
// - Module reset bit in control zero forces the reset state.
// - Resume is driven while the drive resume bit is set.
// - K-state in low-power suspend sets resume flag and wake request.
// - Bus reset brings the device out of suspend.
// - Error enable bit 1 gates checksum errors, bit 0 PID errors.
`include "usb_status_params.svh"
`default_nettype none
module usb_device_status (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire usb_status_pkg::line_state_t line_state,
	input wire logic token_done,
	input wire logic [7:0] token_status,
	input wire logic sof_seen,
	input wire logic [10:0] sof_frame,
	input wire logic checksum_error,
	input wire logic pid_error,
	output logic irq_out,
	output logic wake_req,
	output logic drive_resume,
	output logic clock_enable,
	output logic regulator_enable,
	output logic [6:0] device_address,
	output usb_status_pkg::dev_state_t device_state
);
	import usb_status_pkg::*;

	logic [7:0] fifo_mem [`FIFO_DEPTH];
	logic [1:0] rd_ptr_reg;
	logic [1:0] wr_ptr_reg;
	logic [`FIFO_CNT_W-1:0] count_reg;
	logic [7:0] int_status_reg;
	logic [7:0] int_enable_reg;
	logic [7:0] err_enable_reg;
	logic [7:0] ctl0_reg;
	logic [7:0] lp_reg;
	logic [10:0] frame_reg;
	logic [6:0] addr_reg;
	dev_state_t state_reg;
	logic [`SE0_CNT_W-1:0] se0_cnt_reg;
	logic se0_done_reg;
	logic ph_write_reg;
	logic ph_read_reg;
	logic [5:0] ph_addr_reg;
	logic [31:0] rdata_reg;
	logic irq_reg;

	// Address phase capture; the slave is always zero wait state.
	wire addr_phase = hsel & hready & htrans[1];
	wire mod_reset = ctl0_reg[`BIT_MOD_RESET];
	wire soft_rst = mod_reset;
	wire [7:0] wbyte = hwdata[7:0];
	wire wr_int_status = ph_write_reg & (ph_addr_reg == `ADDR_INT_STATUS);
	wire wr_int_enable = ph_write_reg & (ph_addr_reg == `ADDR_INT_ENABLE);
	wire wr_err_enable = ph_write_reg & (ph_addr_reg == `ADDR_ERR_ENABLE);
	wire wr_ctl0 = ph_write_reg & (ph_addr_reg == `ADDR_CONTROL_ZERO);
	wire wr_addr = ph_write_reg & (ph_addr_reg == `ADDR_DEV_ADDRESS);
	wire wr_state = ph_write_reg & (ph_addr_reg == `ADDR_DEV_STATE);
	wire wr_lp = ph_write_reg & (ph_addr_reg == `ADDR_LP_STATUS);
	wire [5:0] rd_sel = haddr[5:0];

	// SE0 length
	// Only edges that see SE0 count, so exactly 2.5 us of SE0 is ignored and one more edge resets.
	wire se0_now = (line_state == line_se0);
	wire bus_reset_pulse = se0_now & (se0_cnt_reg == `SE0_CNT_W'(`BUS_RESET_CYC - 1)) & ~se0_done_reg;

	// Token-complete flag clear by write-one; FIFO pops on that clear.
	wire tok_flag = int_status_reg[`BIT_TOKEN_DONE];
	wire tok_clear = wr_int_status & wbyte[`BIT_TOKEN_DONE] & tok_flag;
	wire fifo_full = (count_reg == `FIFO_CNT_W'(`FIFO_DEPTH));
	// A full queue drops the newest result; firmware that falls four behind loses that status.
	// push on completion
	wire fifo_push = token_done & ~fifo_full;
	wire fifo_pop = tok_clear & (count_reg != '0);
	wire [`FIFO_CNT_W-1:0] count_next = count_reg + `FIFO_CNT_W'(fifo_push) - `FIFO_CNT_W'(fifo_pop);
	// Flag reasserts while entries remain; otherwise stays clear until a push.
	wire tok_set = (count_next != '0) & (~tok_flag | tok_clear);

	wire lp_suspend = lp_reg[`BIT_LP_SUSPEND];
	wire lp_enable = lp_reg[`BIT_LP_RESUME_EN];
	wire lp_resume_evt = lp_enable & lp_suspend & (line_state == line_k);

	// Error events only latch when enabled.
	// error enables
	wire chk_evt = checksum_error & err_enable_reg[`BIT_CHK_ERR];
	wire pid_evt = pid_error & err_enable_reg[`BIT_PID_ERR];

	function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr, input logic [7:0] set);
		w1c = (cur & ~clr) | set;
	endfunction : w1c

	// Each hardware event sets its own flag bit, and in w1c the set wins over a clear.
	wire [7:0] int_set = ({7'h00, bus_reset_pulse} << `BIT_BUS_RESET)
		| ({7'h00, sof_seen} << `BIT_FRAME_START)
		| ({7'h00, lp_resume_evt} << `BIT_RESUME)
		| ({7'h00, tok_set} << `BIT_TOKEN_DONE)
		| ({7'h00, chk_evt} << `BIT_CHK_FLAG)
		| ({7'h00, pid_evt} << `BIT_PID_FLAG);
	wire [7:0] int_clr = wr_int_status ? wbyte : 8'h00;
	wire [7:0] int_status_next = w1c(int_status_reg, int_clr, int_set);

	wire [7:0] ctl0_next = wr_ctl0 ? wbyte : ctl0_reg;
	wire [7:0] stat_view = tok_flag ? fifo_mem[rd_ptr_reg] : 8'h00;
	wire [7:0] lp_view = {lp_reg[7:3], int_status_reg[`BIT_RESUME], lp_reg[1:0]};

	// Read data is taken at the address phase, so a read never sees a write of the same data phase.
	wire [31:0] rd_mux =
		(rd_sel == `ADDR_INT_STATUS) ? {24'h000000, int_status_reg} :
		(rd_sel == `ADDR_INT_ENABLE) ? {24'h000000, int_enable_reg} :
		(rd_sel == `ADDR_ERR_ENABLE) ? {24'h000000, err_enable_reg} :
		(rd_sel == `ADDR_TRANS_STATUS) ? {24'h000000, stat_view} :
		(rd_sel == `ADDR_FRAME_LOW) ? {24'h000000, frame_reg[7:0]} :
		(rd_sel == `ADDR_FRAME_HIGH) ? {29'h00000000, frame_reg[10:8]} :
		(rd_sel == `ADDR_CONTROL_ZERO) ? {24'h000000, ctl0_reg} :
		(rd_sel == `ADDR_DEV_ADDRESS) ? {25'h0000000, addr_reg} :
		(rd_sel == `ADDR_DEV_STATE) ? {30'h00000000, state_reg} :
		(rd_sel == `ADDR_LP_STATUS) ? {24'h000000, lp_view} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_write_reg <= 1'b0;
			ph_read_reg <= 1'b0;
			ph_addr_reg <= 6'h00;
			rdata_reg <= 32'h00000000;
		end else begin
			ph_write_reg <= addr_phase & hwrite;
			ph_read_reg <= addr_phase & ~hwrite;
			ph_addr_reg <= haddr[5:0];
			if (addr_phase & ~hwrite) begin
				rdata_reg <= rd_mux;
			end
		end
	end

	// The counter stops once the reset is flagged, so a long SE0 raises the flag only once.
	// SE0 timer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			se0_cnt_reg <= '0;
			se0_done_reg <= 1'b0;
		end else if (!se0_now) begin
			se0_cnt_reg <= '0;
			se0_done_reg <= 1'b0;
		end else if (bus_reset_pulse) begin
			se0_done_reg <= 1'b1;
		end else if (!se0_done_reg) begin
			se0_cnt_reg <= se0_cnt_reg + `SE0_CNT_W'(1);
		end
	end

	always_ff @(posedge hclk) begin
		if (fifo_push) begin
			fifo_mem[wr_ptr_reg] <= token_status;
		end
	end

	// A bus reset also empties the queue, since older results belong to a lost configuration.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_ptr_reg <= 2'h0;
			wr_ptr_reg <= 2'h0;
			count_reg <= '0;
		end else if (soft_rst || bus_reset_pulse) begin
			rd_ptr_reg <= 2'h0;
			wr_ptr_reg <= 2'h0;
			count_reg <= '0;
		end else begin
			rd_ptr_reg <= rd_ptr_reg + 2'(fifo_pop);
			wr_ptr_reg <= wr_ptr_reg + 2'(fifo_push);
			count_reg <= count_next;
		end
	end

	// flags set wins over write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_status_reg <= 8'h00;
		end else if (soft_rst) begin
			int_status_reg <= 8'h00;
		end else begin
			int_status_reg <= int_status_next;
		end
	end

	// module reset defaults; reset bit holds everything else in reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl0_reg <= `CTL0_RESET_VAL;
			int_enable_reg <= 8'h00;
			err_enable_reg <= 8'h00;
		end else if (soft_rst) begin
			ctl0_reg <= wr_ctl0 ? wbyte : (`CTL0_RESET_VAL | (8'h01 << `BIT_MOD_RESET));
			int_enable_reg <= 8'h00;
			err_enable_reg <= 8'h00;
		end else begin
			ctl0_reg <= ctl0_next;
			if (wr_int_enable) begin
				int_enable_reg <= wbyte;
			end
			if (wr_err_enable) begin
				err_enable_reg <= wbyte;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_reg <= 11'h000;
		end else if (soft_rst) begin
			frame_reg <= 11'h000;
		end else if (sof_seen) begin
			frame_reg <= sof_frame;
		end
	end

	// bus reset to unconfigured; bus reset leaves suspend
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			addr_reg <= 7'h00;
			state_reg <= dev_unconfigured;
			lp_reg <= 8'h00;
		end else if (soft_rst || bus_reset_pulse) begin
			addr_reg <= 7'h00;
			state_reg <= dev_unconfigured;
			lp_reg <= 8'h00;
		end else begin
			if (wr_addr) begin
				addr_reg <= wbyte[6:0];
			end
			if (wr_state) begin
				state_reg <= dev_state_t'(wbyte[1:0]);
			end
			// A K-state in the cycle of a write still ends suspend, so a wake is never lost.
			if (wr_lp) begin
				lp_reg <= {5'h00, 1'b0, wbyte[`BIT_LP_SUSPEND] & ~lp_resume_evt, wbyte[`BIT_LP_RESUME_EN]};
			end else if (lp_resume_evt) begin
				lp_reg[`BIT_LP_SUSPEND] <= 1'b0;
			end
		end
	end

	// Interrupt line combines flags with enables; masked after module reset.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_reg <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			irq_reg <= |(int_status_next & int_enable_reg) & ~soft_rst;
			wake_req <= lp_resume_evt;
		end
	end

	assign hrdata = rdata_reg;
	// Every transfer ends with no wait state and an OKAY response, so these stay constant.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign irq_out = irq_reg;
	assign drive_resume = ctl0_reg[`BIT_DRIVE_RESUME];
	assign clock_enable = ctl0_reg[`BIT_CLOCK_ENABLE];
	assign regulator_enable = ctl0_reg[`BIT_REG_ENABLE];
	assign device_address = addr_reg;
	assign device_state = state_reg;

	tok_reassert_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tok_clear && count_reg > 1 && !soft_rst |=> int_status_reg[`BIT_TOKEN_DONE]) else $error("token flag not reasserted");
	tok_empty_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tok_clear && count_reg == 1 && !token_done |=> !int_status_reg[`BIT_TOKEN_DONE]) else $error("token flag set on empty fifo");
	fifo_bound_a: assert property (@(posedge hclk) disable iff (!hresetn)
		count_reg <= `FIFO_DEPTH) else $error("fifo overflow");
	reset_delay_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(int_status_reg[`BIT_BUS_RESET]) |-> $past(se0_now, 2)) else $error("bus reset too early");
	addr_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		bus_reset_pulse |=> addr_reg == 7'h00 && state_reg == dev_unconfigured) else $error("bus reset missed");
	frame_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		sof_seen && !soft_rst |=> int_status_reg[`BIT_FRAME_START] && frame_reg == $past(sof_frame)) else $error("frame");
	err_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		checksum_error && !err_enable_reg[`BIT_CHK_ERR] && !soft_rst && !int_status_reg[`BIT_CHK_FLAG] && !wr_int_status
		|=> !int_status_reg[`BIT_CHK_FLAG]) else $error("checksum error not gated");
	mod_mask_a: assert property (@(posedge hclk) disable iff (!hresetn)
		soft_rst |=> int_enable_reg == 8'h00 && !irq_out) else $error("module reset did not mask");
	wake_k_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lp_resume_evt |=> wake_req && !lp_reg[`BIT_LP_SUSPEND]) else $error("resume wake missed");

	// Queue order: a push into an empty queue is shown at once, pops advance, a full queue drops.
	push_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fifo_push && count_reg == '0 && !soft_rst && !bus_reset_pulse |=> tok_flag && stat_view == $past(token_status)) else $error("first status not shown");
	drop_full_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fifo_full && token_done && !fifo_pop && !soft_rst && !bus_reset_pulse |=> count_reg == `FIFO_CNT_W'(`FIFO_DEPTH)) else $error("full queue changed");
	pop_next_a: assert property (@(posedge hclk) disable iff (!hresetn)
		fifo_pop && !soft_rst && !bus_reset_pulse |=> rd_ptr_reg == $past(rd_ptr_reg) + 2'h1) else $error("pop did not advance");

	// Bus reset and suspend.
	bus_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		bus_reset_pulse && !soft_rst |=> int_status_reg[`BIT_BUS_RESET]) else $error("bus reset flag missed");
	suspend_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
		bus_reset_pulse && lp_suspend |=> !lp_reg[`BIT_LP_SUSPEND]) else $error("bus reset kept suspend");
	resume_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		lp_resume_evt && !soft_rst |=> int_status_reg[`BIT_RESUME]) else $error("resume flag missed");

	// Module reset defaults, control bits, the PID error gate and the frame register.
	default_cfg_a: assert property (@(posedge hclk) disable iff (!hresetn)
		soft_rst && !wr_ctl0 |=> clock_enable && !regulator_enable && ctl0_reg[`BIT_MOD_RESET]) else $error("module reset defaults wrong");
	mod_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		soft_rst |=> count_reg == '0 && int_status_reg == 8'h00 && frame_reg == 11'h000) else $error("module reset left state");
	pid_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pid_error && !err_enable_reg[`BIT_PID_ERR] && !soft_rst && !int_status_reg[`BIT_PID_FLAG] && !wr_int_status
		|=> !int_status_reg[`BIT_PID_FLAG]) else $error("pid error not gated");
	resume_pin_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_ctl0 |=> drive_resume == $past(wbyte[`BIT_DRIVE_RESUME])) else $error("resume drive not written");
	frame_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!sof_seen && !soft_rst |=> frame_reg == $past(frame_reg)) else $error("frame number changed");
	drop_c: cover property (@(posedge hclk) disable iff (!hresetn) fifo_full && token_done);
	fifo_fill_c: cover property (@(posedge hclk) disable iff (!hresetn) count_reg == `FIFO_DEPTH);
	reassert_c: cover property (@(posedge hclk) disable iff (!hresetn) tok_clear && count_reg == 2);
	bus_reset_c: cover property (@(posedge hclk) disable iff (!hresetn) bus_reset_pulse);
	resume_c: cover property (@(posedge hclk) disable iff (!hresetn) lp_resume_evt);
endmodule : usb_device_status
`default_nettype wire

// file: usb_host_model.sv
// Behavioural USB host that drives line states, token results, frame starts and error pulses.
`default_nettype none
module usb_host_model (
	input wire logic hclk,
	output usb_status_pkg::line_state_t line_state,
	output logic token_done,
	output logic [7:0] token_status,
	output logic sof_seen,
	output logic [10:0] sof_frame,
	output logic checksum_error,
	output logic pid_error
);
	timeunit 1ns;
	timeprecision 1ns;
	import usb_status_pkg::*;
	initial begin
		line_state = line_j;
		token_done = 1'b0;
		token_status = 8'h00;
		sof_seen = 1'b0;
		sof_frame = 11'h000;
		checksum_error = 1'b0;
		pid_error = 1'b0;
	end
	// Back-to-back results; the status bus shows the inverse of the first result once released so stale data is not mistaken for valid.
	task automatic tokens(input logic [39:0] sts, input int n);
		for (int i = 0; i < n; i++) begin
			token_done <= 1'b1;
			token_status <= sts[8*i+:8];
			@(posedge hclk);
		end
		token_done <= 1'b0;
		token_status <= ~sts[7:0];
	endtask : tokens
	task automatic sof(input logic [10:0] f);
		sof_seen <= 1'b1;
		sof_frame <= f;
		@(posedge hclk);
		sof_seen <= 1'b0;
		sof_frame <= ~f;
	endtask : sof
	task automatic errs(input logic c, input logic p);
		checksum_error <= c;
		pid_error <= p;
		@(posedge hclk);
		checksum_error <= 1'b0;
		pid_error <= 1'b0;
	endtask : errs
	task automatic line(input line_state_t s, input int n);
		line_state <= s;
		repeat (n) @(posedge hclk);
		line_state <= line_j;
	endtask : line
endmodule : usb_host_model
`default_nettype wire

// file: usb_device_status_and_reset_test.sv
// Testbench for the USB device status and reset block.
`include "usb_status_params.svh"
`default_nettype none
module usb_device_status_and_reset_test;
	timeunit 1ns;
	timeprecision 1ns;
	import usb_status_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hready, hresp, irq_out, wake_req, drive_resume, clock_enable, regulator_enable;
	logic [31:0] hrdata, rd;
	logic [6:0] device_address;
	dev_state_t device_state;
	line_state_t line_state;
	logic token_done, sof_seen, checksum_error, pid_error;
	logic [7:0] token_status;
	logic [10:0] sof_frame;
	logic [39:0] sts = 40'h98_34_f8_78_08;
	logic [23:0] setup_sts = 24'h08_0d_0d;
	int failures = 0;
	int num_checks = 0;
	int wakes = 0;
	always #25 hclk = ~hclk;
	always @(posedge hclk) if (wake_req === 1'b1) wakes++;
	usb_device_status usb_device_status_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hready), .hresp(hresp), .line_state(line_state), .token_done(token_done),
		.token_status(token_status), .sof_seen(sof_seen), .sof_frame(sof_frame), .checksum_error(checksum_error),
		.pid_error(pid_error), .irq_out(irq_out), .wake_req(wake_req), .drive_resume(drive_resume),
		.clock_enable(clock_enable), .regulator_enable(regulator_enable), .device_address(device_address),
		.device_state(device_state));
	usb_host_model usb_host_model_inst (.hclk(hclk), .line_state(line_state), .token_done(token_done),
		.token_status(token_status), .sof_seen(sof_seen), .sof_frame(sof_frame),
		.checksum_error(checksum_error), .pid_error(pid_error));
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		haddr <= {26'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask : bus
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rdc(input string n, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask : rdc
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic conclude;
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (4000) @(posedge hclk);
		failures++;
		conclude();
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdc("ctl0", `ADDR_CONTROL_ZERO, 32'h10);
		rdc("int_en", `ADDR_INT_ENABLE, 32'h0);
		chk("clk_reg", 32'h2, {30'h0, clock_enable, regulator_enable});
		rdc("unmapped", 6'h3c, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		wr(`ADDR_INT_ENABLE, 32'hed);
		wr(`ADDR_ERR_ENABLE, 32'h0);
		usb_host_model_inst.errs(1'b1, 1'b1);
		repeat (2) @(posedge hclk);
		chk("irq_err_off", 32'h0, {31'h0, irq_out});
		wr(`ADDR_INT_STATUS, 32'hff);
		wr(`ADDR_ERR_ENABLE, 32'h3);
		rdc("err_en", `ADDR_ERR_ENABLE, 32'h3);
		usb_host_model_inst.errs(1'b1, 1'b0);
		repeat (2) @(posedge hclk);
		chk("irq_chk_on", 32'h1, {31'h0, irq_out});
		rdc("chk_flag", `ADDR_INT_STATUS, 32'h40);
		wr(`ADDR_INT_STATUS, 32'hff);
		usb_host_model_inst.errs(1'b0, 1'b1);
		rdc("pid_flag", `ADDR_INT_STATUS, 32'h80);
		wr(`ADDR_INT_STATUS, 32'hff);
		rdc("stat_idle", `ADDR_TRANS_STATUS, 32'h0);
		// Five results back to back: the queue holds four, so the last one must be lost.
		usb_host_model_inst.tokens(sts, 5);
		repeat (2) @(posedge hclk);
		for (int i = 0; i < 4; i++) begin
			rdc("tok_flag", `ADDR_INT_STATUS, 32'h08);
			chk("irq_tok", 32'h1, {31'h0, irq_out});
			rdc("stat", `ADDR_TRANS_STATUS, {24'h0, sts[8*i+:8]});
			wr(`ADDR_INT_STATUS, 32'h08);
		end
		rdc("tok_empty", `ADDR_INT_STATUS, 32'h0);
		rdc("stat_empty", `ADDR_TRANS_STATUS, 32'h0);
		chk("irq_empty", 32'h0, {31'h0, irq_out});
		// Setup, a retried setup and the zero-length status stage all queue for endpoint zero.
		usb_host_model_inst.tokens({16'h0000, setup_sts}, 3);
		repeat (2) @(posedge hclk);
		for (int i = 0; i < 3; i++) begin
			rdc("ep0_stat", `ADDR_TRANS_STATUS, {24'h0, setup_sts[8*i+:8]});
			chk("ep0_field", 32'h0, {28'h0, rd[7:4]});
			wr(`ADDR_INT_STATUS, 32'h08);
		end
		rdc("tok_empty2", `ADDR_INT_STATUS, 32'h0);
		usb_host_model_inst.sof(11'h5a3);
		rdc("sof_flag", `ADDR_INT_STATUS, 32'h04);
		rdc("frame_lo", `ADDR_FRAME_LOW, 32'ha3);
		rdc("frame_hi", `ADDR_FRAME_HIGH, 32'h05);
		wr(`ADDR_INT_STATUS, 32'hff);
		wr(`ADDR_LP_STATUS, 32'h3);
		wakes = 0;
		usb_host_model_inst.line(line_k, 4);
		chk("wake", 32'h1, {31'h0, wakes > 0});
		bus(1'b0, `ADDR_LP_STATUS, 32'h0);
		chk("lp_flag", 32'h4, rd & 32'h4);
		rdc("resume_flag", `ADDR_INT_STATUS, 32'h20);
		wr(`ADDR_DEV_ADDRESS, 32'h2a);
		wr(`ADDR_DEV_STATE, 32'h2);
		rdc("state_set", `ADDR_DEV_STATE, 32'h2);
		wr(`ADDR_LP_STATUS, 32'h3);
		usb_host_model_inst.line(line_se0, 50);
		repeat (2) @(posedge hclk);
		rdc("addr_short", `ADDR_DEV_ADDRESS, 32'h2a);
		bus(1'b0, `ADDR_INT_STATUS, 32'h0);
		chk("rst_short", 32'h0, rd & 32'h1);
		usb_host_model_inst.line(line_se0, 51);
		repeat (2) @(posedge hclk);
		chk("addr_port", 32'h0, {25'h0, device_address});
		chk("state", 32'h1, {31'h0, device_state === dev_unconfigured});
		bus(1'b0, `ADDR_INT_STATUS, 32'h0);
		chk("rst_flag", 32'h1, rd & 32'h1);
		bus(1'b0, `ADDR_LP_STATUS, 32'h0);
		chk("suspend", 32'h0, rd & 32'h2);
		wr(`ADDR_INT_STATUS, 32'hff);
		wr(`ADDR_CONTROL_ZERO, 32'h14);
		@(posedge hclk);
		chk("resume_on", 32'h1, {31'h0, drive_resume});
		wr(`ADDR_CONTROL_ZERO, 32'h10);
		@(posedge hclk);
		chk("resume_off", 32'h0, {31'h0, drive_resume});
		wr(`ADDR_CONTROL_ZERO, 32'h50);
		@(posedge hclk);
		chk("reg_on", 32'h1, {31'h0, regulator_enable});
		usb_host_model_inst.sof(11'h123);
		wr(`ADDR_CONTROL_ZERO, 32'h80);
		@(posedge hclk);
		rdc("ctl0_mr", `ADDR_CONTROL_ZERO, 32'h90);
		chk("reg_mr", 32'h0, {31'h0, regulator_enable});
		wr(`ADDR_CONTROL_ZERO, 32'h10);
		rdc("int_en_mr", `ADDR_INT_ENABLE, 32'h0);
		rdc("int_st_mr", `ADDR_INT_STATUS, 32'h0);
		rdc("frame_mr", `ADDR_FRAME_LOW, 32'h0);
		chk("clk_mr", 32'h1, {31'h0, clock_enable});
		conclude();
	end
endmodule : usb_device_status_and_reset_test
`default_nettype wire
